// ===== rtl/fault_flag_trim_defines.vh
// Register offsets, field positions, reset values and codes for the fault flag and trim bank
`ifndef FAULT_FLAG_TRIM_DEFINES_VH
`define FAULT_FLAG_TRIM_DEFINES_VH

// Register indices (byte address = 4 * index)
`define REG_UV_HYS          16'hfe51
`define REG_LINE_OFS        16'hfe53
`define REG_CUR_OFS_LO      16'hfe54
`define REG_CUR_GAIN_HI     16'hfe7e
`define REG_CUR_OFS_HI      16'hfe7f
`define REG_FLAGS_A         16'hfe80
`define REG_FLAGS_B         16'hfe81
`define REG_FLAGS_C         16'hfe82
`define REG_MOD_READBACK    16'hfe84
`define REG_CONTROL         16'hfef0
`define REG_STATUS          16'hfef1

// Address width of the bus (word address = index)
`define ADDR_W              16

// Reset values
`define RST_BYTE            8'h00
`define RST_FLAGS           8'h00

// Valid bit masks of the latched registers
`define MASK_FLAGS_A        8'hff
`define MASK_FLAGS_B        8'h7f
`define MASK_FLAGS_C        8'h3e

// Gain trim field
`define GAIN_SIGN_BIT       7

// Control register fields
`define CTL_UNLOCK_BIT      0
`define CTL_CUR_RANGE_BIT   1

// Fault response encoding for the disable-output choice
`define REACT_DISABLE       2'h2

// Read answer for an unmapped address
`define UNMAPPED_DATA       32'h00000000

`endif

// ===== rtl/fault_flag_trim_registers.v
// Fault flag, trim and modulation read-back register bank on Avalon-MM
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "fault_flag_trim_defines.vh"

// Behaviour
// - Undervoltage hysteresis used only under disable-output fault reaction.
// - Undervoltage recovery when input exceeds limit plus 8-bit hysteresis.
// - Trim registers accept writes only while trim lock is open.
// - Line converter offset trim always subtracted from raw output.
// - Separate low/high range current offsets; active range one is subtracted.
// - High-range gain trim bit 7 is sign, bits 6:0 magnitude.
// - Latched flags set on condition and stay set afterwards.
// - Reading a latched register clears only that register.
// - Register A bit 7 max modulation, bit 6 min modulation.
// - Register A bit 5 suspected open voltage divider.
// - Register A bit 4 quick overvoltage comparator crossing.
// - Undetected line period substitutes maximum period and sets A bit 3.
// - Register A bit 2 line voltage below turn-on threshold.
// - Register A bit 1 startup ramp, bit 0 bypass relay off.
// - Register B bit 6 memory unlocked, bit 5 memory check failed.
// - Register B bit 4 address resistor near decode boundary.
// - Register B bit 3 high line, bit 2 overcurrent, bit 1 sync lock.
// - Register B bit 0 line-good combination; 1 means pin driven low.
// - Register C bit 5 low power, bit 4 fast loop filter active.
// - Register C bits 3,2,1 core over, supply over, supply under.
// - Read-back returns eight MSBs of 10-bit modulation value.
// - Overvoltage recovery below limit minus hysteresis, disable-output reaction only.
module fault_flag_trim_registers (
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Avalon-MM slave
  input  wire [15:0] i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Fault reaction and limits from the protection logic
  input  wire [1:0]  i_input_undervoltage_reaction,
  input  wire [1:0]  i_output_overvoltage_reaction,
  input  wire [7:0]  i_input_undervoltage_limit,
  input  wire [7:0]  i_output_overvoltage_limit,
  input  wire [7:0]  i_output_overvoltage_hysteresis,
  input  wire [7:0]  i_input_voltage,
  input  wire [7:0]  i_output_voltage,
  // Raw converter samples
  input  wire [11:0] i_line_raw,
  input  wire [11:0] i_current_raw,
  input  wire        i_line_period_valid,
  input  wire [7:0]  i_line_period_meas,
  input  wire [9:0]  i_modulation_value,
  // Flag conditions, grouped per latched register
  input  wire [7:0]  i_cond_a,
  input  wire [7:0]  i_cond_b,
  input  wire [7:0]  i_cond_c,
  // Block outputs
  output reg         o_input_uv_shutdown,
  output reg         o_output_ov_shutdown,
  output reg  [11:0] o_line_corrected,
  output reg  [11:0] o_current_corrected,
  output reg         o_current_gain_negative,
  output reg  [6:0]  o_current_gain_magnitude,
  output reg  [7:0]  o_line_period
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  //
  // All state lives in flip-flops on i_clk; every input is taken as already
  // synchronous to that clock, so no input passes a synchroniser here.
  // Trims and the hysteresis are plain bytes; the three latched registers
  // are held as one small array so that one generate loop serves them all.
  // The control register carries the trim unlock and the current range
  // select; the status register shows recovery state and line period.

  localparam [7:0] PERIOD_MAX = 8'hff;

  reg  [7:0]  input_uv_recover_hysteresis;
  reg  [7:0]  line_adc_offset_trim;
  reg  [7:0]  current_adc_offset_trim_low_range;
  reg  [7:0]  current_adc_gain_trim_high_range;
  reg  [7:0]  current_adc_offset_trim_high_range;
  reg  [7:0]  flags [0:2];
  reg         trim_unlocked;
  reg         current_range_high;
  reg         read_done;
  reg  [31:0] next_readdata;
  reg  [7:0]  active_offset;
  wire        wr;
  wire        rd;
  wire        wr_lo;
  wire        trim_wr_ok;
  wire [8:0]  uv_release_level;
  wire [7:0]  ov_release_level;
  wire [7:0]  cond [0:2];
  wire [7:0]  mask [0:2];
  wire [7:0]  line_cycle_undetected_cond;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle on reads, writes taken at once
  //
  // Read timing, cycle by cycle:
  //   first cycle  - read high, waitrequest high, read data registered
  //   second cycle - waitrequest low, master takes the data at its end
  // A clearing read therefore samples the flags one edge before it clears
  // them; the clear itself lands at the edge the master takes the data.
  // Writes never wait: the register changes at the edge write is seen.
  // Only byte lane 0 carries data; a write without that lane does nothing.
  // The tracker drops back after each read, so back-to-back reads each
  // get their own wait cycle and readdata is never stale.

  assign wr                = i_avs_write;
  assign rd                = i_avs_read & read_done;
  assign o_avs_waitrequest = i_avs_read & ~read_done;
  assign wr_lo             = wr & i_avs_byteenable[0];
  assign trim_wr_ok        = wr_lo & trim_unlocked;

  // Read phase tracker
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_done <= 1'b0;
    end else begin
      read_done <= i_avs_read & ~read_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  //
  // The hysteresis byte and the control register are always writable.
  // The four converter trims change only while the unlock bit is set;
  // a write while locked is dropped without any error indication.
  // A write to the control register updates the unlock bit itself, so
  // software relocks the trims by writing zero there.

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_uv_recover_hysteresis        <= `RST_BYTE;
      line_adc_offset_trim               <= `RST_BYTE;
      current_adc_offset_trim_low_range  <= `RST_BYTE;
      current_adc_gain_trim_high_range   <= `RST_BYTE;
      current_adc_offset_trim_high_range <= `RST_BYTE;
      trim_unlocked                      <= 1'b0;
      current_range_high                 <= 1'b0;
    end else begin
      if (wr_lo && i_avs_address == `REG_UV_HYS) begin
        input_uv_recover_hysteresis <= i_avs_writedata[7:0];
      end
      if (wr_lo && i_avs_address == `REG_CONTROL) begin
        trim_unlocked      <= i_avs_writedata[`CTL_UNLOCK_BIT];
        current_range_high <= i_avs_writedata[`CTL_CUR_RANGE_BIT];
      end
      // Trims only while unlocked
      if (trim_wr_ok) begin
        case (i_avs_address)
          `REG_LINE_OFS: begin
            line_adc_offset_trim <= i_avs_writedata[7:0];
          end
          `REG_CUR_OFS_LO: begin
            current_adc_offset_trim_low_range <= i_avs_writedata[7:0];
          end
          `REG_CUR_GAIN_HI: begin
            current_adc_gain_trim_high_range <= i_avs_writedata[7:0];
          end
          `REG_CUR_OFS_HI: begin
            current_adc_offset_trim_high_range <= i_avs_writedata[7:0];
          end
          default: begin
            // Other addresses leave the trims alone
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags
  //
  // Each bit sets on its condition and stays until software reads the
  // register that holds it. Only the addressed register clears, and only
  // at the edge the read completes. A condition present at that edge
  // survives the clear, but one present only at the sampling edge is lost in the
  // clear. Reserved positions are masked so they always read zero.
  // Register A bit 3 also sets while the line period is undetected.

  assign line_cycle_undetected_cond = {4'h0, ~i_line_period_valid, 3'h0};
  assign cond[0] = i_cond_a | line_cycle_undetected_cond;
  assign cond[1] = i_cond_b;
  assign cond[2] = i_cond_c;
  assign mask[0] = `MASK_FLAGS_A;
  assign mask[1] = `MASK_FLAGS_B;
  assign mask[2] = `MASK_FLAGS_C;

  // Set wins over the read clear; only the addressed register clears
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : latch
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          flags[g] <= `RST_FLAGS;
        end else if (rd && i_avs_address == (`REG_FLAGS_A + g)) begin
          flags[g] <= cond[g] & mask[g];
        end else begin
          flags[g] <= (flags[g] | cond[g]) & mask[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Unmapped addresses, and upper bits of every register but status, read as zero
  always @* begin
    next_readdata = `UNMAPPED_DATA;
    case (i_avs_address)
      `REG_UV_HYS: begin
        next_readdata = {24'h0, input_uv_recover_hysteresis};
      end
      `REG_LINE_OFS: begin
        next_readdata = {24'h0, line_adc_offset_trim};
      end
      `REG_CUR_OFS_LO: begin
        next_readdata = {24'h0, current_adc_offset_trim_low_range};
      end
      `REG_CUR_GAIN_HI: begin
        next_readdata = {24'h0, current_adc_gain_trim_high_range};
      end
      `REG_CUR_OFS_HI: begin
        next_readdata = {24'h0, current_adc_offset_trim_high_range};
      end
      `REG_FLAGS_A: begin
        next_readdata = {24'h0, flags[0]};
      end
      `REG_FLAGS_B: begin
        next_readdata = {24'h0, flags[1]};
      end
      `REG_FLAGS_C: begin
        next_readdata = {24'h0, flags[2]};
      end
      `REG_MOD_READBACK: begin
        // Upper eight of the ten modulation bits
        next_readdata = {24'h0, i_modulation_value[9:2]};
      end
      `REG_CONTROL: begin
        next_readdata = {30'h0, current_range_high, trim_unlocked};
      end
      `REG_STATUS: begin
        // Line period in the low byte, recovery state above it
        next_readdata = {22'h0, o_output_ov_shutdown, o_input_uv_shutdown, o_line_period};
      end
      default: begin
        next_readdata = `UNMAPPED_DATA;
      end
    endcase
  end

  // Read data registered during the wait cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && !read_done) begin
      o_avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault recovery with hysteresis

  assign uv_release_level = {1'b0, i_input_undervoltage_limit} + {1'b0, input_uv_recover_hysteresis};
  assign ov_release_level = (i_output_overvoltage_limit > i_output_overvoltage_hysteresis) ?
                            (i_output_overvoltage_limit - i_output_overvoltage_hysteresis) : 8'h00;

  // The release levels are compared strictly, so a voltage sitting exactly
  // on the level keeps the output off; this avoids chatter at the edge.
  // The release sum is nine bits wide so a large hysteresis cannot wrap.
  // The overvoltage release floors at zero for the same reason.

  // Undervoltage: hysteresis only in disable-output reaction
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_input_uv_shutdown <= 1'b0;
    end else begin
      if (i_input_undervoltage_reaction != `REACT_DISABLE) begin
        o_input_uv_shutdown <= 1'b0;
      end else if (i_input_voltage < i_input_undervoltage_limit) begin
        o_input_uv_shutdown <= 1'b1;
      end else if ({1'b0, i_input_voltage} > uv_release_level) begin
        o_input_uv_shutdown <= 1'b0;
      end
    end
  end

  // Overvoltage: mirror with limit minus hysteresis
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_ov_shutdown <= 1'b0;
    end else begin
      if (i_output_overvoltage_reaction != `REACT_DISABLE) begin
        o_output_ov_shutdown <= 1'b0;
      end else if (i_output_voltage > i_output_overvoltage_limit) begin
        o_output_ov_shutdown <= 1'b1;
      end else if (i_output_voltage < ov_release_level) begin
        o_output_ov_shutdown <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter correction

  always @* begin
    active_offset = current_range_high ? current_adc_offset_trim_high_range
                                       : current_adc_offset_trim_low_range;
  end

  // Offsets are only ever subtracted; the result wraps modulo 2^12, so a
  // raw sample below the trim comes out as a large value. Every output
  // here carries one cycle of latency from its inputs.

  // Line converter: offset always taken away
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_corrected <= 12'h000;
    end else begin
      o_line_corrected <= i_line_raw - {4'h0, line_adc_offset_trim};
    end
  end

  // Current converter: offset of the selected range taken away
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_current_corrected <= 12'h000;
    end else begin
      o_current_corrected <= i_current_raw - {4'h0, active_offset};
    end
  end

  // High range gain trim split into sign and magnitude
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_current_gain_negative  <= 1'b0;
      o_current_gain_magnitude <= 7'h00;
    end else begin
      o_current_gain_negative  <= current_adc_gain_trim_high_range[`GAIN_SIGN_BIT];
      o_current_gain_magnitude <= current_adc_gain_trim_high_range[6:0];
    end
  end

  // Line period, forced to the maximum while undetected
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_period <= 8'h00;
    end else begin
      o_line_period <= i_line_period_valid ? i_line_period_meas : PERIOD_MAX;
    end
  end

endmodule
`default_nettype wire

// ===== verif/fault_flag_trim_checker.sv
// Assertion checker for the fault flag and trim register bank
`timescale 1ns/1ns
`default_nettype none
`include "fault_flag_trim_defines.vh"
module fault_flag_trim_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [1:0]  i_input_undervoltage_reaction,
  input wire logic [1:0]  i_output_overvoltage_reaction,
  input wire logic [7:0]  i_input_undervoltage_limit,
  input wire logic [7:0]  i_output_overvoltage_limit,
  input wire logic [7:0]  i_input_voltage,
  input wire logic [7:0]  i_output_voltage,
  input wire logic        i_line_period_valid,
  input wire logic [9:0]  i_modulation_value,
  input wire logic [7:0]  i_cond_a,
  input wire logic        o_input_uv_shutdown,
  input wire logic        o_output_ov_shutdown,
  input wire logic [7:0]  o_line_period
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire [7:0] mod_hi = i_modulation_value[9:2];
  // Read handshake steps
  sequence rd_wait_s; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
  sequence rd_done_s; i_avs_read && !o_avs_waitrequest; endsequence
  AST_RD_WAIT: assert property ($rose(i_avs_read) |-> rd_wait_s) else $error("read without one wait cycle");
  AST_MOD_RB: assert property (rd_done_s ##0 i_avs_address == `REG_MOD_READBACK |->
    o_avs_readdata == {24'h0, $past(mod_hi)}) else $error("modulation readback wrong");
  AST_FLAG_A: assert property (rd_done_s ##0 i_avs_address == `REG_FLAGS_A |->
    (o_avs_readdata[7:0] & $past(i_cond_a, 2)) == $past(i_cond_a, 2)) else $error("flag A lost");
  AST_RSVD_HI: assert property (rd_done_s ##0 i_avs_address != `REG_STATUS |->
    o_avs_readdata[31:8] == 24'h0) else $error("upper read bits not zero");
  AST_RSVD_C: assert property (rd_done_s ##0 i_avs_address == `REG_FLAGS_C |->
    (o_avs_readdata[7:0] & 8'hc1) == 8'h00) else $error("reserved C bits set");
  AST_PERIOD_MAX: assert property (!i_line_period_valid |=> o_line_period == 8'hff)
    else $error("period not forced to max");
  AST_UV_OTHER: assert property (i_input_undervoltage_reaction != 2'h2 |=> !o_input_uv_shutdown)
    else $error("uv shutdown under other reaction");
  AST_UV_TRIP: assert property (i_input_undervoltage_reaction == 2'h2 &&
    i_input_voltage < i_input_undervoltage_limit |=> o_input_uv_shutdown) else $error("uv not tripped");
  AST_UV_HOLD: assert property (i_input_undervoltage_reaction == 2'h2 && o_input_uv_shutdown &&
    i_input_voltage <= i_input_undervoltage_limit |=> o_input_uv_shutdown) else $error("uv released early");
  AST_OV_OTHER: assert property (i_output_overvoltage_reaction != 2'h2 |=> !o_output_ov_shutdown)
    else $error("ov shutdown under other reaction");
  AST_OV_TRIP: assert property (i_output_overvoltage_reaction == 2'h2 &&
    i_output_voltage > i_output_overvoltage_limit |=> o_output_ov_shutdown) else $error("ov not tripped");
endmodule
bind fault_flag_trim_registers fault_flag_trim_checker u_chk (.i_clk, .i_rst_n, .i_avs_address, .i_avs_read,
  .o_avs_readdata, .o_avs_waitrequest, .i_input_undervoltage_reaction, .i_output_overvoltage_reaction,
  .i_input_undervoltage_limit, .i_output_overvoltage_limit, .i_input_voltage, .i_output_voltage,
  .i_line_period_valid, .i_modulation_value, .i_cond_a, .o_input_uv_shutdown, .o_output_ov_shutdown,
  .o_line_period);
`default_nettype wire

// ===== verif/fault_flag_trim_registers_tb.sv
// Self-checking testbench for the fault flag and trim register bank
`timescale 1ns/1ns
`default_nettype none
`include "fault_flag_trim_defines.vh"
module fault_flag_trim_registers_tb;
  logic i_clk = 0, i_rst_n = 0, i_avs_read = 0, i_avs_write = 0, i_line_period_valid = 1;
  logic [15:0] i_avs_address = 0;
  logic [31:0] i_avs_writedata = 0, d;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic [1:0] i_input_undervoltage_reaction = 0, i_output_overvoltage_reaction = 0;
  logic [7:0] i_input_undervoltage_limit = 0, i_output_overvoltage_limit = 0, i_output_overvoltage_hysteresis = 0;
  logic [7:0] i_input_voltage = 0, i_output_voltage = 0, i_line_period_meas = 0, i_cond_a = 0, i_cond_b = 0, i_cond_c = 0;
  logic [11:0] i_line_raw = 0, i_current_raw = 0;
  logic [9:0] i_modulation_value = 0;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, o_input_uv_shutdown, o_output_ov_shutdown, o_current_gain_negative;
  wire [11:0] o_line_corrected, o_current_corrected;
  wire [6:0] o_current_gain_magnitude;
  wire [7:0] o_line_period;
  int n_fail = 0, samples_checked = 0;
  logic [15:0] ra [9] = '{`REG_UV_HYS, `REG_LINE_OFS, `REG_CUR_OFS_LO, `REG_CUR_GAIN_HI, `REG_CUR_OFS_HI,
                          `REG_FLAGS_A, `REG_FLAGS_B, `REG_FLAGS_C, `REG_MOD_READBACK};
  fault_flag_trim_registers uut (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task chk(input [31:0] s, input [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [15:0] a, input [7:0] v);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, v};
    i_avs_write <= 1;
    @(posedge i_clk);
    while (o_avs_waitrequest) @(posedge i_clk);
    i_avs_write <= 0;
  endtask
  task rc(input [15:0] a, input [31:0] e);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_read <= 1;
    @(posedge i_clk);
    while (o_avs_waitrequest) @(posedge i_clk);
    d = o_avs_readdata;
    i_avs_read <= 0;
    chk(d, e);
  endtask
  task settle;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task pulse(input [7:0] a);
    @(posedge i_clk);
    {i_cond_a, i_cond_b, i_cond_c} <= {a, a, a};
    @(posedge i_clk);
    {i_cond_a, i_cond_b, i_cond_c} <= 24'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place and read-only write
  task t_regs;
    foreach (ra[i]) rc(ra[i], 32'h0);
    wr(16'h0123, 8'h5a);
    rc(16'h0123, 32'h0);
    wr(`REG_MOD_READBACK, 8'h5a);
    rc(`REG_MOD_READBACK, 32'h0);
    $display("t_regs done");
  endtask
  // Trim lock and offset subtraction
  task t_trim;
    wr(`REG_LINE_OFS, 8'h05);
    rc(`REG_LINE_OFS, 32'h0);
    wr(`REG_CONTROL, 8'h01);
    wr(`REG_LINE_OFS, 8'h05);
    rc(`REG_LINE_OFS, 32'h05);
    i_line_raw <= 12'h100;
    settle;
    chk(o_line_corrected, 12'h0fb);
    @(posedge i_clk) i_line_raw <= 12'h002;
    settle;
    chk(o_line_corrected, 12'hffd);
    wr(`REG_CUR_OFS_LO, 8'h03);
    wr(`REG_CUR_OFS_HI, 8'h07);
    wr(`REG_CUR_GAIN_HI, 8'h85);
    i_current_raw <= 12'h010;
    settle;
    chk(o_current_corrected, 12'h00d);
    wr(`REG_CONTROL, 8'h03);
    settle;
    chk(o_current_corrected, 12'h009);
    chk({o_current_gain_negative, o_current_gain_magnitude}, 8'h85);
    wr(`REG_CUR_GAIN_HI, 8'h7f);
    settle;
    chk({o_current_gain_negative, o_current_gain_magnitude}, 8'h7f);
    wr(`REG_CONTROL, 8'h00);
    wr(`REG_CUR_GAIN_HI, 8'h00);
    rc(`REG_CUR_GAIN_HI, 32'h7f);
    $display("t_trim done");
  endtask
  // Latched flags, clear on read, event in the clearing cycle
  task t_flags;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      rc(`REG_FLAGS_A, 32'h01 << i);
      rc(`REG_FLAGS_B, (32'h01 << i) & 32'h7f);
      rc(`REG_FLAGS_C, (32'h01 << i) & 32'h3e);
    end
    pulse(8'hff);
    rc(`REG_FLAGS_A, 32'hff);
    rc(`REG_FLAGS_A, 32'h00);
    rc(`REG_FLAGS_B, 32'h7f);
    rc(`REG_FLAGS_C, 32'h3e);
    @(posedge i_clk) i_cond_a <= 8'h01;
    rc(`REG_FLAGS_A, 32'h01);
    i_cond_a <= 8'h00;
    rc(`REG_FLAGS_A, 32'h01);
    rc(`REG_FLAGS_A, 32'h00);
    @(posedge i_clk) i_line_period_valid <= 0;
    settle;
    chk(o_line_period, 8'hff);
    @(posedge i_clk) i_line_period_valid <= 1;
    rc(`REG_FLAGS_A, 32'h08);
    $display("t_flags done");
  endtask
  // Recovery hysteresis and modulation read-back
  task t_prot;
    wr(`REG_UV_HYS, 8'h10);
    {i_input_undervoltage_limit, i_input_undervoltage_reaction, i_input_voltage} <= {8'h40, 2'h2, 8'h30};
    settle;
    chk(o_input_uv_shutdown, 1'b1);
    @(posedge i_clk) i_input_voltage <= 8'h50;
    settle;
    chk(o_input_uv_shutdown, 1'b1);
    @(posedge i_clk) i_input_voltage <= 8'h51;
    settle;
    chk(o_input_uv_shutdown, 1'b0);
    @(posedge i_clk) {i_input_undervoltage_reaction, i_input_voltage} <= {2'h0, 8'h30};
    settle;
    chk(o_input_uv_shutdown, 1'b0);
    @(posedge i_clk) {i_output_overvoltage_limit, i_output_overvoltage_hysteresis} <= {8'h80, 8'h10};
    {i_output_overvoltage_reaction, i_output_voltage} <= {2'h2, 8'h90};
    settle;
    chk(o_output_ov_shutdown, 1'b1);
    @(posedge i_clk) i_output_voltage <= 8'h70;
    settle;
    chk(o_output_ov_shutdown, 1'b1);
    @(posedge i_clk) i_output_voltage <= 8'h6f;
    settle;
    chk(o_output_ov_shutdown, 1'b0);
    @(posedge i_clk) i_modulation_value <= 10'h3a5;
    rc(`REG_MOD_READBACK, 32'he9);
    $display("t_prot done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1;
    t_regs;
    t_trim;
    t_flags;
    t_prot;
    finish_test;
  end
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
